// File: common/mzio_consts.svh
// Offsets, field positions, reset values and sizes of the mezzanine I/O register window.
`ifndef MZIO_CONSTS_SVH
`define MZIO_CONSTS_SVH

// ==========================================================================
// Register offsets, relative to the carrier's memory-space base address
// ==========================================================================
`define MZIO_OFS_STAT 21'h0_8000
`define MZIO_OFS_DDATA 21'h0_8004
`define MZIO_OFS_DDIR 21'h0_8008
`define MZIO_OFS_SDATA 21'h0_800C
`define MZIO_OFS_SDIR 21'h0_8010
`define MZIO_OFS_IEN 21'h0_8014
`define MZIO_OFS_ITYP 21'h0_8018
`define MZIO_OFS_IPOL 21'h0_801C
`define MZIO_WIN_LO 21'h0_8000
`define MZIO_WIN_END 21'h0_802C

// ==========================================================================
// Field positions
// ==========================================================================
`define MZIO_SWRST_BIT 31
`define MZIO_ID_LSB 13
`define MZIO_ID_MSB 15
`define MZIO_PEND_MSB 7
`define MZIO_INT_LSB 8

// ==========================================================================
// Sizes and reset values
// ==========================================================================
`define MZIO_NDIFF 30
`define MZIO_NSE 16
`define MZIO_NCOS 8
`define MZIO_COS_FIRST 8
`define MZIO_RST_WORD 32'h0000_0000
`define MZIO_RST_BYTE 8'h00

`endif

// File: common/mzio_pkg.sv
// Types shared by the mezzanine I/O register window.
package mzio_pkg;

   // ==========================================================================
   // Register selection inside the decoded window
   // ==========================================================================
   typedef enum {
      MZIO_SEL_STAT,
      MZIO_SEL_DDATA,
      MZIO_SEL_DDIR,
      MZIO_SEL_SDATA,
      MZIO_SEL_SDIR,
      MZIO_SEL_IEN,
      MZIO_SEL_ITYP,
      MZIO_SEL_IPOL,
      MZIO_SEL_UNUSED,
      MZIO_SEL_NONE
   } mzio_sel_e;

   typedef logic [31:0] mzio_word_t;

endpackage : mzio_pkg

// File: hw/mzio_cos_detect.sv
// Change-of-state and level detector with sticky pending bits for eight channels.
`timescale 1ns/10ps
`include "mzio_consts.svh"

module mzio_cos_detect #(
   parameter int NCH = `MZIO_NCOS
) (
   // Clock and reset (hardware or software reset).
   input wire logic clk,
   input wire logic rst,
   // Synchronised channel levels.
   input wire logic [NCH-1:0] lvl,
   // Configuration: enable, type (1 = edge, 0 = level), polarity (1 = high/rising).
   input wire logic [NCH-1:0] en,
   input wire logic [NCH-1:0] typ,
   input wire logic [NCH-1:0] pol,
   // Write-one-to-clear mask.
   input wire logic [NCH-1:0] clr,
   // Sticky pending bits.
   output logic [NCH-1:0] pend
);

   logic [NCH-1:0] prev_q;
   logic [NCH-1:0] set;
   logic [NCH-1:0] pend_q;

   // Previous level, kept for edge detection; reset loads the live level so no false edge follows.
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= lvl;
      end else begin
         prev_q <= lvl;
      end
   end

   // ==========================================================================
   // Per-channel event and pending logic
   // ==========================================================================
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // Edge mode fires on the selected transition, level mode while the level holds.
         assign set[g] = en[g] & (typ[g] ? ((lvl[g] ^ prev_q[g]) & (lvl[g] == pol[g]))
                                         : (lvl[g] == pol[g]));

         // A set arriving with a clear wins, so no event is lost.
         always_ff @(posedge clk) begin
            if (rst) begin
               pend_q[g] <= 1'b0;
            end else if (set[g]) begin
               pend_q[g] <= 1'b1;
            end else if (clr[g]) begin
               pend_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign pend = pend_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_set_pends;
      @(posedge clk) disable iff (rst) (set != '0) |=> ((pend & $past(set)) == $past(set));
   endproperty
   a_set_pends: assert property (p_set_pends) else $error("event did not set pending");

   property p_clear_releases;
      @(posedge clk) disable iff (rst)
         ((clr & ~set) != '0) |=> ((pend & $past(clr & ~set)) == '0);
   endproperty
   a_clear_releases: assert property (p_clear_releases) else $error("clear ignored");

   property p_pend_sticky;
      @(posedge clk) disable iff (rst)
         1'b1 |=> (((pend & ~$past(pend)) & ~$past(set)) == '0) &&
                  ((($past(pend) & ~$past(clr)) & ~pend) == '0);
   endproperty
   a_pend_sticky: assert property (p_pend_sticky) else $error("pending bit moved alone");

   c_pend_then_clear: cover property (@(posedge clk) disable iff (rst)
      (pend[0] && !set[0]) ##1 clr[0] ##1 !pend[0]);

endmodule : mzio_cos_detect

// File: hw/mzio_regs.sv
// Register window, soft reset and channel control of the digital I/O daughter card.
//
// Overview of operation
// - Window accepts 32, 16 and 8-bit reads and writes on every register.
// - Unused offsets and unused bits inside the window read as zero.
// - Byte lanes are little endian; byte enable 0 is the lowest byte.
// - Writing one to status bit 31 resets carrier and all card registers.
// - Status bits 15 to 13 are a read-only card identity code.
// - Status bits 0 to 7 show pending interrupts of channels 8 to 15.
// - Writing one to a status bit 0 to 7 clears that pending interrupt, unless a new event or a held level sets it in that same cycle.
// - Writing zero to a pending bit leaves it unchanged.
// - Status bits 12 to 8 and 30 to 16 belong to the carrier.
// - Offsets below 0x8000 or from 0x802C upward are not decoded here.
// - Offset 0x8018 lower half holds interrupt type for channels 15 to 8.
// - Offset 0x801C lower half holds interrupt polarity for channels 15 to 8.
// - Emulation lines take the differential channels' place in their registers.
// - Sixteen auxiliary lines map one to one onto single-ended register bits.
// - Each differential channel 0 to 29 has its own direction bit.
// - Direction zero makes a channel input, one makes it output.
// - After any reset all direction bits are zero, all channels inputs.
`timescale 1ns/10ps
`include "mzio_consts.svh"

module mzio_regs
   import mzio_pkg::*;
#(
   parameter int NDIFF = `MZIO_NDIFF,
   parameter int NSE = `MZIO_NSE,
   parameter logic [2:0] CARD_ID = 3'h2 // Arbitrary value, replace per card variant.
) (
   // Clock and synchronous reset.
   input wire logic clk,
   input wire logic srst,
   // Memory-space register access from the carrier (byte offset).
   input wire logic [20:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [3:0] bus_be,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic bus_ack,
   output logic bus_hit,
   // Software reset request toward the carrier logic.
   output logic soft_reset,
   // Pending change-of-state status for the carrier's interrupt logic.
   output logic [`MZIO_NCOS-1:0] irq_pending,
   // Differential (or emulation) channels.
   input wire logic [NDIFF-1:0] diff_in,
   output logic [NDIFF-1:0] diff_out,
   output logic [NDIFF-1:0] diff_oe_n,
   // Single-ended (or auxiliary) channels.
   input wire logic [NSE-1:0] se_in,
   output logic [NSE-1:0] se_out,
   output logic [NSE-1:0] se_oe_n
);

   localparam int NCOS = `MZIO_NCOS;

   // ==========================================================================
   // Helper functions
   // ==========================================================================

   // Maps an offset onto a register of the window, or none outside it.
   function automatic mzio_sel_e decode(input logic [20:0] a);
      mzio_sel_e s;
      s = MZIO_SEL_NONE;
      if (a >= `MZIO_WIN_LO && a < `MZIO_WIN_END) begin
         case ({a[20:2], 2'b00})
            `MZIO_OFS_STAT: s = MZIO_SEL_STAT;
            `MZIO_OFS_DDATA: s = MZIO_SEL_DDATA;
            `MZIO_OFS_DDIR: s = MZIO_SEL_DDIR;
            `MZIO_OFS_SDATA: s = MZIO_SEL_SDATA;
            `MZIO_OFS_SDIR: s = MZIO_SEL_SDIR;
            `MZIO_OFS_IEN: s = MZIO_SEL_IEN;
            `MZIO_OFS_ITYP: s = MZIO_SEL_ITYP;
            `MZIO_OFS_IPOL: s = MZIO_SEL_IPOL;
            default: s = MZIO_SEL_UNUSED;
         endcase
      end
      return s;
   endfunction : decode

   // Merges write data into a word lane by lane; lane 0 is the lowest byte.
   function automatic mzio_word_t merge(input mzio_word_t old, input mzio_word_t wd,
                                        input logic [3:0] be);
      mzio_word_t r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ==========================================================================
   // Decode and register state
   // ==========================================================================
   mzio_sel_e sel;
   logic wr_en;
   logic rst_all;
   logic swrst_q;
   logic [NDIFF-1:0] ddata_q;
   logic [NDIFF-1:0] ddir_q;
   logic [NSE-1:0] sdata_q;
   logic [NSE-1:0] sdir_q;
   logic [NCOS-1:0] ien_q;
   logic [NCOS-1:0] ityp_q;
   logic [NCOS-1:0] ipol_q;
   logic [NDIFF-1:0] dsync1_q;
   logic [NDIFF-1:0] dsync2_q;
   logic [NSE-1:0] ssync1_q;
   logic [NSE-1:0] ssync2_q;
   logic [NCOS-1:0] pend;
   logic [NCOS-1:0] clr;
   mzio_word_t rd_mux;
   mzio_word_t ddata_rd;
   mzio_word_t sdata_rd;

   // Host offsets already have the carrier base removed by the carrier decode.
   assign sel = decode(bus_addr);
   assign bus_hit = (sel != MZIO_SEL_NONE);
   assign wr_en = bus_wr & bus_hit;
   assign rst_all = srst | swrst_q;

   // Soft reset: one pulse after a write of one to bit 31, then resets all registers except the pin synchronisers and the bus answer.
   always_ff @(posedge clk) begin
      if (srst) begin
         swrst_q <= 1'b0;
      end else begin
         swrst_q <= wr_en && sel == MZIO_SEL_STAT && bus_be[3] &&
                    bus_wdata[`MZIO_SWRST_BIT];
      end
   end
   assign soft_reset = swrst_q;

   // Two-flop synchronisers on the channel pins.
   always_ff @(posedge clk) begin
      if (srst) begin
         dsync1_q <= '0;
         dsync2_q <= '0;
         ssync1_q <= '0;
         ssync2_q <= '0;
      end else begin
         dsync1_q <= diff_in;
         dsync2_q <= dsync1_q;
         ssync1_q <= se_in;
         ssync2_q <= ssync1_q;
      end
   end

   // Differential data and direction registers.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         ddata_q <= '0;
         ddir_q <= '0;
      end else if (wr_en && sel == MZIO_SEL_DDATA) begin
         ddata_q <= NDIFF'(merge(mzio_word_t'(ddata_q), bus_wdata, bus_be));
      end else if (wr_en && sel == MZIO_SEL_DDIR) begin
         ddir_q <= NDIFF'(merge(mzio_word_t'(ddir_q), bus_wdata, bus_be));
      end
   end

   // Single-ended data and direction registers.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         sdata_q <= '0;
         sdir_q <= '0;
      end else if (wr_en && sel == MZIO_SEL_SDATA) begin
         sdata_q <= NSE'(merge(mzio_word_t'(sdata_q), bus_wdata, bus_be));
      end else if (wr_en && sel == MZIO_SEL_SDIR) begin
         sdir_q <= NSE'(merge(mzio_word_t'(sdir_q), bus_wdata, bus_be));
      end
   end

   // Interrupt enable, type and polarity sit in bits 15 to 8 of their words.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         ien_q <= `MZIO_RST_BYTE;
         ityp_q <= `MZIO_RST_BYTE;
         ipol_q <= `MZIO_RST_BYTE;
      end else if (wr_en && bus_be[1]) begin
         if (sel == MZIO_SEL_IEN) begin
            ien_q <= bus_wdata[`MZIO_INT_LSB +: NCOS];
         end
         if (sel == MZIO_SEL_ITYP) begin
            ityp_q <= bus_wdata[`MZIO_INT_LSB +: NCOS];
         end
         if (sel == MZIO_SEL_IPOL) begin
            ipol_q <= bus_wdata[`MZIO_INT_LSB +: NCOS];
         end
      end
   end

   // ==========================================================================
   // Change-of-state detection on differential channels 15 to 8
   // ==========================================================================
   assign clr = (wr_en && sel == MZIO_SEL_STAT && bus_be[0]) ?
                bus_wdata[`MZIO_PEND_MSB:0] : '0;

   mzio_cos_detect #(
      .NCH(NCOS)
   ) u_cos (
      .clk(clk),
      .rst(rst_all),
      .lvl(dsync2_q[`MZIO_COS_FIRST +: NCOS]),
      .en(ien_q),
      .typ(ityp_q),
      .pol(ipol_q),
      .clr(clr),
      .pend(pend)
   );
   assign irq_pending = pend;

   // ==========================================================================
   // Pin drive
   // ==========================================================================

   // A direction bit of one drives the pin; the enable is low while driving.
   assign diff_out = ddata_q;
   assign diff_oe_n = ~ddir_q;
   assign se_out = sdata_q;
   assign se_oe_n = ~sdir_q;

   // ==========================================================================
   // Read path
   // ==========================================================================

   // Outputs read back their written value, inputs their pin level.
   assign ddata_rd = mzio_word_t'((ddir_q & ddata_q) | (~ddir_q & dsync2_q));
   assign sdata_rd = mzio_word_t'((sdir_q & sdata_q) | (~sdir_q & ssync2_q));

   // Selects the word to return; unused words and bits read zero.
   always_comb begin
      rd_mux = `MZIO_RST_WORD;
      case (sel)
         MZIO_SEL_STAT: begin
            rd_mux[`MZIO_PEND_MSB:0] = pend;
            rd_mux[`MZIO_ID_MSB:`MZIO_ID_LSB] = CARD_ID;
         end
         MZIO_SEL_DDATA: rd_mux = ddata_rd;
         MZIO_SEL_DDIR: rd_mux = mzio_word_t'(ddir_q);
         MZIO_SEL_SDATA: rd_mux = sdata_rd;
         MZIO_SEL_SDIR: rd_mux = mzio_word_t'(sdir_q);
         MZIO_SEL_IEN: rd_mux[`MZIO_INT_LSB +: NCOS] = ien_q;
         MZIO_SEL_ITYP: rd_mux[`MZIO_INT_LSB +: NCOS] = ityp_q;
         MZIO_SEL_IPOL: rd_mux[`MZIO_INT_LSB +: NCOS] = ipol_q;
         default: rd_mux = `MZIO_RST_WORD;
      endcase
   end

   // Registered answer one cycle after the request; the full word is returned.
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_rdata <= `MZIO_RST_WORD;
         bus_ack <= 1'b0;
      end else begin
         bus_rdata <= (bus_rd && bus_hit) ? rd_mux : `MZIO_RST_WORD;
         bus_ack <= (bus_rd | bus_wr) & bus_hit;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_dir_drives;
      @(posedge clk) disable iff (srst)
         (wr_en && sel == MZIO_SEL_DDIR && bus_be == 4'hF && !swrst_q)
         |=> (diff_oe_n == ~$past(bus_wdata[NDIFF-1:0]));
   endproperty
   a_dir_drives: assert property (p_dir_drives) else $error("direction not on pins");

   property p_byte_lane;
      @(posedge clk) disable iff (srst)
         (wr_en && sel == MZIO_SEL_DDIR && bus_be == 4'h1 && !swrst_q)
         |=> (ddir_q[7:0] == $past(bus_wdata[7:0])) &&
             (ddir_q[NDIFF-1:8] == $past(ddir_q[NDIFF-1:8]));
   endproperty
   a_byte_lane: assert property (p_byte_lane) else $error("byte lane leaked");

   property p_soft_reset;
      @(posedge clk) disable iff (srst)
         (wr_en && sel == MZIO_SEL_STAT && bus_be[3] && bus_wdata[31])
         |=> soft_reset ##1 (!soft_reset && diff_oe_n == '1 && ien_q == '0 && pend == '0);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed");

   property p_id_read;
      @(posedge clk) disable iff (srst)
         (bus_rd && sel == MZIO_SEL_STAT)
         |=> bus_ack && bus_rdata[15:13] == CARD_ID && bus_rdata[31:16] == '0 &&
             bus_rdata[12:8] == '0;
   endproperty
   a_id_read: assert property (p_id_read) else $error("identity field wrong");

   property p_pend_read;
      @(posedge clk) disable iff (srst)
         (bus_rd && sel == MZIO_SEL_STAT) |=> bus_rdata[7:0] == $past(pend);
   endproperty
   a_pend_read: assert property (p_pend_read) else $error("pending status wrong");

   property p_unused_zero;
      @(posedge clk) disable iff (srst)
         (bus_rd && sel == MZIO_SEL_UNUSED) |=> bus_ack && bus_rdata == '0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused offset not zero");

   property p_outside;
      @(posedge clk) disable iff (srst)
         (bus_addr < `MZIO_WIN_LO || bus_addr >= `MZIO_WIN_END) && bus_rd
         |-> !bus_hit ##1 !bus_ack;
   endproperty
   a_outside: assert property (p_outside) else $error("decoded outside window");

   property p_reset_inputs;
      @(posedge clk) disable iff (srst)
         $fell(srst) |-> diff_oe_n == '1 && se_oe_n == '1 && ityp_q == '0 && ipol_q == '0;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("channel not input");

   c_soft_reset: cover property (@(posedge clk) disable iff (srst) soft_reset);
   c_byte_write: cover property (@(posedge clk) disable iff (srst)
      wr_en && sel == MZIO_SEL_SDATA && bus_be == 4'h2);
   c_pend_read: cover property (@(posedge clk) disable iff (srst)
      bus_rd && sel == MZIO_SEL_STAT && pend != '0);

endmodule : mzio_regs

// File: bench/mzio_host.sv
// Host bus master model that reaches the card's register window over memory space.
`timescale 1ns/10ps

module mzio_host (
   // Clock.
   input wire logic clk,
   // Requests toward the card.
   output logic [20:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   output logic [3:0] bus_be,
   output logic [31:0] bus_wdata,
   // Answers from the card.
   input wire logic [31:0] bus_rdata,
   input wire logic bus_ack,
   input wire logic bus_hit,
   input wire logic soft_reset
);

   // The bus starts idle and parked outside the window.
   initial begin
      bus_addr = 21'h00_0000;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_be = 4'h0;
      bus_wdata = 32'h0000_0000;
   end

   // One access: raised after a falling edge, taken at the next rising edge, answered a cycle on.
   task automatic xfer(input logic w, input logic [20:0] ofs, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd_data,
                       output logic acked, output logic hit, output logic sr);
      @(negedge clk);
      bus_addr = ofs; // The carrier base is already removed, so only the offset goes out.
      bus_be = be;
      bus_wdata = wd;
      bus_wr = w; // Read and write are never raised together.
      bus_rd = !w;
      #1 hit = bus_hit;
      @(negedge clk);
      rd_data = bus_rdata;
      acked = bus_ack;
      sr = soft_reset;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = ~wd; // Released data shows no stale value.
   endtask : xfer

endmodule : mzio_host

// File: bench/test_mzio_regs.sv
// Self-checking testbench of the mezzanine I/O register window.
`timescale 1ns/10ps
`include "mzio_consts.svh"

module test_mzio_regs;
   import mzio_pkg::*;

   // ==========================================================================
   // Signals and instances
   // ==========================================================================
   localparam logic [2:0] CARD_ID_T = 3'h5; // Arbitrary value.
   logic clk, srst, bus_rd, bus_wr, bus_ack, bus_hit, soft_reset, last_sr;
   logic [20:0] bus_addr;
   logic [3:0] bus_be;
   logic [31:0] bus_wdata, bus_rdata, rd;
   logic [7:0] irq_pending;
   logic [29:0] diff_in, diff_out, diff_oe_n, pin_d;
   logic [15:0] se_in, se_out, se_oe_n;
   int n_fail, samples_checked, cycles;

   // Differential pins read back what the card drives and the bench level elsewhere; single-ended pins read zero when not driven.
   assign diff_in = (pin_d & diff_oe_n) | (diff_out & ~diff_oe_n);
   assign se_in = se_out & ~se_oe_n;

   mzio_regs #(.CARD_ID(CARD_ID_T)) u_dut (.clk(clk), .srst(srst), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_be(bus_be), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_hit(bus_hit), .soft_reset(soft_reset),
      .irq_pending(irq_pending), .diff_in(diff_in), .diff_out(diff_out),
      .diff_oe_n(diff_oe_n), .se_in(se_in), .se_out(se_out), .se_oe_n(se_oe_n));
   mzio_host u_host (.clk(clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .bus_hit(bus_hit), .soft_reset(soft_reset));

   // ==========================================================================
   // Clock, timeout and shared tasks
   // ==========================================================================
   // The clock toggles every 10 ns for a 20 ns period.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // A hang is cut short after a fixed number of cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end

   // Compares one value and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Writes through the host model and expects one acknowledge.
   task automatic bw(input logic [20:0] ofs, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] r;
      logic a, h;
      u_host.xfer(1'b1, ofs, be, d, r, a, h, last_sr);
      chk("write ack", 32'h0000_0001, {31'h0, a});
   endtask : bw

   // Reads through the host model and expects one acknowledge.
   task automatic br(input logic [20:0] ofs, output logic [31:0] d);
      logic a, h, s;
      u_host.xfer(1'b0, ofs, 4'hF, 32'h0000_0000, d, a, h, s);
      chk("read ack", 32'h0000_0001, {31'h0, a});
   endtask : br

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Values after reset, and the unused offsets inside the window.
   task automatic t_reset();
      br(`MZIO_OFS_STAT, rd);
      chk("status", {16'h0000, CARD_ID_T, 13'h0000}, rd);
      br(`MZIO_OFS_DDIR, rd);
      chk("diff dir", 32'h0000_0000, rd);
      chk("diff oe_n", 32'h3FFF_FFFF, {2'b00, diff_oe_n});
      for (int k = 0; k < 3; k++) begin
         br(21'h0_8020 + 21'(4 * k), rd);
         chk("unused", 32'h0000_0000, rd);
      end
   endtask : t_reset

   // Offsets outside the window get no hit and no acknowledge.
   task automatic t_outside();
      logic [20:0] ofs [2];
      logic a, h, s;
      ofs = '{21'h0_7FFC, `MZIO_WIN_END};
      foreach (ofs[i]) begin
         u_host.xfer(1'b0, ofs[i], 4'hF, 32'h0000_0000, rd, a, h, s);
         chk("hit", 32'h0000_0000, {31'h0, h});
         chk("ack", 32'h0000_0000, {31'h0, a});
      end
   endtask : t_outside

   // Word, byte and half-word writes land on their little-endian lanes.
   task automatic t_lanes();
      bw(`MZIO_OFS_DDIR, 4'hF, 32'h1234_5678);
      bw(`MZIO_OFS_DDIR, 4'h2, 32'h0000_AB00);
      br(`MZIO_OFS_DDIR, rd);
      chk("byte lane", 32'h1234_AB78, rd);
      bw(`MZIO_OFS_DDIR, 4'hC, 32'hFFFF_0000);
      br(`MZIO_OFS_DDIR, rd);
      chk("half lane", 32'h3FFF_AB78, rd);
      chk("oe_n", ~32'h3FFF_AB78 & 32'h3FFF_FFFF, {2'b00, diff_oe_n});
      bw(`MZIO_OFS_STAT, 4'h2, 32'h0000_E000);
      br(`MZIO_OFS_STAT, rd);
      chk("id held", {16'h0000, CARD_ID_T, 13'h0000}, rd);
   endtask : t_lanes

   // Data and direction of both channel groups.
   task automatic t_chan();
      bw(`MZIO_OFS_DDIR, 4'hF, 32'h3FFF_FFFF);
      bw(`MZIO_OFS_DDATA, 4'hF, 32'h2AAA_5555);
      br(`MZIO_OFS_DDATA, rd);
      chk("diff data", 32'h2AAA_5555, rd);
      chk("diff out", 32'h2AAA_5555, {2'b00, diff_out});
      bw(`MZIO_OFS_SDIR, 4'hF, 32'hFFFF_FFFF);
      br(`MZIO_OFS_SDIR, rd);
      chk("se dir", 32'h0000_FFFF, rd);
      chk("se oe_n", 32'h0000_0000, {16'h0000, se_oe_n});
      bw(`MZIO_OFS_SDATA, 4'h3, 32'h0000_A5C3);
      chk("se out", 32'h0000_A5C3, {16'h0000, se_out});
   endtask : t_chan

   // Rising edge on channel 8 sets a sticky bit; zero keeps it, one clears it.
   task automatic t_irq();
      bw(`MZIO_OFS_DDIR, 4'hF, 32'h0000_0000);
      // Type and polarity go first, so a half-configured channel cannot raise an event.
      bw(`MZIO_OFS_ITYP, 4'h2, 32'h0000_0100);
      bw(`MZIO_OFS_IPOL, 4'h2, 32'h0000_0100);
      bw(`MZIO_OFS_IEN, 4'h2, 32'h0000_0100);
      br(`MZIO_OFS_ITYP, rd);
      chk("type", 32'h0000_0100, rd);
      br(`MZIO_OFS_IPOL, rd);
      chk("polarity", 32'h0000_0100, rd);
      chk("no pend", 32'h0000_0000, {24'h0, irq_pending});
      pin_d[8] = 1'b1;
      repeat (5) @(negedge clk);
      chk("pend", 32'h0000_0001, {24'h0, irq_pending});
      br(`MZIO_OFS_STAT, rd);
      chk("stat pend", 32'h0000_0001, rd & 32'h0000_00FF);
      br(`MZIO_OFS_DDATA, rd);
      chk("diff in", 32'h0000_0100, rd);
      bw(`MZIO_OFS_STAT, 4'h1, 32'h0000_0000);
      chk("kept", 32'h0000_0001, {24'h0, irq_pending});
      bw(`MZIO_OFS_STAT, 4'h1, 32'h0000_0001);
      chk("cleared", 32'h0000_0000, {24'h0, irq_pending});
      // Level mode keeps setting the bit while the high level stands, so a clear loses.
      bw(`MZIO_OFS_ITYP, 4'h2, 32'h0000_0000);
      @(negedge clk);
      chk("level pend", 32'h0000_0001, {24'h0, irq_pending});
      bw(`MZIO_OFS_STAT, 4'h1, 32'h0000_0001);
      chk("level held", 32'h0000_0001, {24'h0, irq_pending});
   endtask : t_irq

   // Software reset pulses, clears the pending bit and returns differential direction, enable and type to their defaults.
   task automatic t_swrst();
      pin_d[8] = 1'b0;
      bw(`MZIO_OFS_DDIR, 4'hF, 32'h0000_0200);
      repeat (3) @(negedge clk);
      bw(`MZIO_OFS_STAT, 4'h1, 32'h0000_0001);
      chk("pend low", 32'h0000_0000, {24'h0, irq_pending});
      pin_d[8] = 1'b1;
      repeat (5) @(negedge clk);
      chk("pend again", 32'h0000_0001, {24'h0, irq_pending});
      bw(`MZIO_OFS_STAT, 4'h8, 32'h8000_0000);
      chk("soft reset", 32'h0000_0001, {31'h0, last_sr});
      @(negedge clk);
      chk("pend zero", 32'h0000_0000, {24'h0, irq_pending});
      chk("oe_n reset", 32'h3FFF_FFFF, {2'b00, diff_oe_n});
      br(`MZIO_OFS_IEN, rd);
      chk("enable", 32'h0000_0000, rd);
      br(`MZIO_OFS_ITYP, rd);
      chk("type zero", 32'h0000_0000, rd);
   endtask : t_swrst

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   // Inputs are set at time zero, reset is held for six cycles, then each scenario runs.
   initial begin
      n_fail = 0;
      samples_checked = 0;
      cycles = 0;
      srst = 1'b1;
      pin_d = 30'h0000_0000;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_outside();
      t_lanes();
      t_chan();
      t_irq();
      t_swrst();
      complete_run();
   end

endmodule : test_mzio_regs
